// file: bspm_top.sv
// boot select, interrupt arbitration and idle / power-down control
// assumes the core honours the halt and service handshakes below
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - external code select low boots at zero
// - straps sampled at reset release force vector
// - strap status flag set when straps low
// - zero bit, then user bit, else default
// - boot control bits default to one
// - boot bits programmed by flash or host commands
// - user vector placed at bits 13:6 or 12:5
// - seven sources, four priority levels each
// - fixed vector address per source
// - fixed service order within one level
// - power-down wakes only via level external interrupt
// - idle bit halts program counter only
// - registers held during idle
// - idle bit cleared when service starts
// - reset in low power restarts like power-on
// - strobes high in idle, low in power-down
// - power-down stops clock, level interrupts live
// - power-down bit cleared when service starts
// - wake pin held low 1024 cycles
// - state preserved through power-down
module bspm_top
	import bspm_pkg::*;
#(
	parameter bit LARGE_MEM = 1'b1,
	parameter logic [15:0] DEFAULT_BOOT_VEC = DEFAULT_BOOT_VEC_RST
) (
	// clock, reset, enable
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// pins
	input wire logic i_external_code_select_n,
	input wire logic [1:0] i_port1_strap,
	input wire logic i_ext_irq0_pin_n,
	input wire logic i_ext_irq1_pin_n,
	// boot control programming
	input wire logic i_boot_cfg_wr,
	input wire bspm_boot_cfg_t i_boot_cfg_wdata,
	// power control register write
	input wire logic i_power_control_reg_wr,
	input wire logic [7:0] i_power_control_reg_wdata,
	// interrupt flags, enables and priorities
	input wire logic [NUM_IRQ-1:0] i_irq_flag,
	input wire logic [NUM_IRQ-1:0] i_irq_en,
	input wire logic [NUM_IRQ*PRIO_W-1:0] i_irq_prio,
	input wire logic i_global_irq_en,
	input wire logic [1:0] i_ext_irq_edge_mode,
	input wire logic i_irq_ack,
	// boot outputs
	output logic [15:0] o_boot_addr,
	output logic o_boot_valid,
	output logic [7:0] o_flash_config_reg,
	output bspm_boot_cfg_t o_boot_cfg,
	// power outputs
	output logic [7:0] o_power_control_reg,
	output logic o_pc_halt,
	output logic o_clk_stop,
	output logic o_addr_latch_strobe,
	output logic o_program_fetch_strobe_n,
	// interrupt outputs
	output logic o_irq_req,
	output logic [2:0] o_irq_src,
	output logic [15:0] o_irq_vector
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic rst_d_ff, nxt_rst_d;
	logic boot_done_ff, nxt_boot_done;
	logic strap_low_ff, nxt_strap_low;
	logic ext_sel_n_ff, nxt_ext_sel_n;
	bspm_boot_cfg_t cfg_ff, nxt_cfg;
	logic [15:0] boot_addr_ff, nxt_boot_addr;
	logic [7:0] power_control_reg_ff, nxt_power_control_reg;
	bspm_pmode_t mode_ff, nxt_mode;
	logic [WAKE_CNT_W-1:0] wake_cnt_ff, nxt_wake_cnt;
	logic [1:0] wake_src_ff, nxt_wake_src;
	logic irq_req_ff, nxt_irq_req;
	logic [2:0] irq_src_ff, nxt_irq_src;
	logic [15:0] irq_vec_ff, nxt_irq_vec;
	logic ale_ff, nxt_ale;
	logic program_fetch_strobe_n_n_ff, nxt_program_fetch_strobe_n_n;
	logic halt_ff, nxt_halt;
	logic cstop_ff, nxt_cstop;

	logic [15:0] sel_addr;
	bspm_irq_sel_t arb_sel;
	logic [NUM_IRQ-1:0] live_req;
	logic [1:0] lvl_wake;

	// ----------------------------------------
	// boot selection
	// ----------------------------------------
	bspm_boot_sel #(
		.LARGE_MEM(LARGE_MEM)
	) u_boot_sel (
		.i_ext_code_sel_n(i_external_code_select_n),
		.i_strap_low(nxt_strap_low),
		.i_cfg(cfg_ff),
		.i_default_vec(DEFAULT_BOOT_VEC),
		.o_boot_addr(sel_addr)
	);

	always_comb begin
		nxt_rst_d = i_sys_rst;
		nxt_boot_done = boot_done_ff;
		nxt_strap_low = strap_low_ff;
		nxt_ext_sel_n = ext_sel_n_ff;
		nxt_boot_addr = boot_addr_ff;
		nxt_cfg = cfg_ff;
		if (i_sys_rst) begin
			nxt_boot_done = 1'b0;
		end else if (rst_d_ff) begin
			// falling edge of reset samples the straps
			nxt_strap_low = (i_port1_strap == 2'b00);
			nxt_ext_sel_n = i_external_code_select_n;
			nxt_boot_addr = sel_addr;
			nxt_boot_done = 1'b1;
		end
		if (i_boot_cfg_wr) begin
			nxt_cfg = i_boot_cfg_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			rst_d_ff <= nxt_rst_d;
			boot_done_ff <= nxt_boot_done;
			strap_low_ff <= nxt_strap_low;
			ext_sel_n_ff <= nxt_ext_sel_n;
			boot_addr_ff <= nxt_boot_addr;
		end
	end

	// boot configuration is nonvolatile: only power-on defaults
	// starts clear so the factory values load on the first reset edges
	logic cfg_init_ff = 1'b0;
	always_ff @(posedge i_clk) begin
		if (i_ce) begin
			if (!cfg_init_ff) begin
				cfg_ff <= '{zero_boot_bit: BOOT_CTRL_FACTORY, user_vec_bit: BOOT_CTRL_FACTORY,
					user_vec: 8'h00};
				cfg_init_ff <= i_sys_rst;
			end else begin
				cfg_ff <= nxt_cfg;
			end
		end
	end

	// ----------------------------------------
	// interrupt arbitration
	// ----------------------------------------
	always_comb begin
		live_req = i_irq_flag & i_irq_en & {NUM_IRQ{i_global_irq_en}};
		lvl_wake[0] = !i_ext_irq0_pin_n && i_irq_en[SRC_EXT0] && !i_ext_irq_edge_mode[0];
		lvl_wake[1] = !i_ext_irq1_pin_n && i_irq_en[SRC_EXT1] && !i_ext_irq_edge_mode[1];
		if (mode_ff == PM_PDOWN) begin
			live_req = '0;
			live_req[SRC_EXT0] = lvl_wake[0] && i_global_irq_en;
			live_req[SRC_EXT1] = lvl_wake[1] && i_global_irq_en;
		end
	end

	bspm_irq_arb u_irq_arb (
		.i_req(live_req),
		.i_prio(i_irq_prio),
		.o_sel(arb_sel)
	);

	// ----------------------------------------
	// power mode control
	// ----------------------------------------
	always_comb begin
		nxt_power_control_reg = power_control_reg_ff;
		nxt_mode = mode_ff;
		nxt_wake_cnt = wake_cnt_ff;
		nxt_wake_src = wake_src_ff;
		nxt_irq_req = irq_req_ff;
		nxt_irq_src = irq_src_ff;
		nxt_irq_vec = irq_vec_ff;
		if (i_irq_ack) begin
			nxt_irq_req = 1'b0;
		end
		case (mode_ff)
			PM_RUN: begin
				if (i_power_control_reg_wr) begin
					nxt_power_control_reg = i_power_control_reg_wdata;
					if (i_power_control_reg_wdata[PD_BIT_POS]) begin
						nxt_mode = PM_PDOWN;
						nxt_wake_cnt = '0;
					end else if (i_power_control_reg_wdata[IDLE_BIT_POS]) begin
						nxt_mode = PM_IDLE;
					end
				end
				if (arb_sel.valid && !irq_req_ff) begin
					nxt_irq_req = 1'b1;
					nxt_irq_src = arb_sel.src;
					nxt_irq_vec = arb_sel.vector;
				end
			end
			PM_IDLE: begin
				// registers untouched; service clears only the idle and power-down bits
				if (arb_sel.valid) begin
					nxt_irq_req = 1'b1;
					nxt_irq_src = arb_sel.src;
					nxt_irq_vec = arb_sel.vector;
					nxt_power_control_reg[IDLE_BIT_POS] = 1'b0;
					nxt_power_control_reg[PD_BIT_POS] = 1'b0;
					nxt_mode = PM_RUN;
				end
			end
			PM_PDOWN: begin
				// wake needs the level held for the full count, then release
				if (lvl_wake != 2'b00) begin
					nxt_wake_src = lvl_wake;
					if (wake_cnt_ff != WAKE_CNT_W'(WAKE_HOLD_CYCLES)) begin
						nxt_wake_cnt = wake_cnt_ff + 1'b1;
					end
				end else if (wake_cnt_ff == WAKE_CNT_W'(WAKE_HOLD_CYCLES)) begin
					nxt_irq_req = 1'b1;
					nxt_irq_src = wake_src_ff[0] ? 3'(SRC_EXT0) : 3'(SRC_EXT1);
					nxt_irq_vec = wake_src_ff[0] ? VEC_EXT0 : VEC_EXT1;
					nxt_power_control_reg[PD_BIT_POS] = 1'b0;
					nxt_power_control_reg[IDLE_BIT_POS] = 1'b0;
					nxt_mode = PM_RUN;
					nxt_wake_cnt = '0;
				end else begin
					nxt_wake_cnt = '0;
				end
			end
			default: nxt_mode = PM_RUN;
		endcase
		nxt_ale = (nxt_mode != PM_PDOWN);
		nxt_program_fetch_strobe_n_n = (nxt_mode != PM_PDOWN);
		nxt_halt = (nxt_mode != PM_RUN);
		nxt_cstop = (nxt_mode == PM_PDOWN);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			power_control_reg_ff <= POWER_CONTROL_REG_RST;
			mode_ff <= PM_RUN;
			wake_cnt_ff <= '0;
			wake_src_ff <= 2'b00;
			irq_req_ff <= 1'b0;
			irq_src_ff <= 3'h0;
			irq_vec_ff <= 16'h0000;
			ale_ff <= 1'b1;
			program_fetch_strobe_n_n_ff <= 1'b1;
			halt_ff <= 1'b0;
			cstop_ff <= 1'b0;
		end else if (i_ce) begin
			power_control_reg_ff <= nxt_power_control_reg;
			mode_ff <= nxt_mode;
			wake_cnt_ff <= nxt_wake_cnt;
			wake_src_ff <= nxt_wake_src;
			irq_req_ff <= nxt_irq_req;
			irq_src_ff <= nxt_irq_src;
			irq_vec_ff <= nxt_irq_vec;
			ale_ff <= nxt_ale;
			program_fetch_strobe_n_n_ff <= nxt_program_fetch_strobe_n_n;
			halt_ff <= nxt_halt;
			cstop_ff <= nxt_cstop;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_comb begin
		o_boot_addr = boot_addr_ff;
		o_boot_valid = boot_done_ff;
		o_flash_config_reg = {1'b0, strap_low_ff, 6'h00};
		o_boot_cfg = cfg_ff;
		o_power_control_reg = power_control_reg_ff;
		o_pc_halt = halt_ff;
		o_clk_stop = cstop_ff;
		o_addr_latch_strobe = ale_ff;
		o_program_fetch_strobe_n = program_fetch_strobe_n_n_ff;
		o_irq_req = irq_req_ff;
		o_irq_src = irq_src_ff;
		o_irq_vector = irq_vec_ff;
	end

endmodule
`default_nettype wire

// file: bspm_pkg.sv
// package for the boot select and power mode block
// assumes a single 100 MHz system clock domain
package bspm_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int WAKE_HOLD_CYCLES = 1024;
	localparam int WAKE_CNT_W = 11;

	// ----------------------------------------
	// addresses and vectors
	// ----------------------------------------
	localparam logic [15:0] ADDR_ZERO = 16'h0000;
	localparam logic [15:0] DEFAULT_BOOT_VEC_RST = 16'h0000;
	localparam int UVEC_LSB_LARGE = 6;
	localparam int UVEC_LSB_SMALL = 5;
	localparam int NUM_IRQ = 7;
	localparam int PRIO_W = 2;
	localparam logic [15:0] VEC_EXT0 = 16'h0003;
	localparam logic [15:0] VEC_WDOG = 16'h0053;
	localparam logic [15:0] VEC_TMR0 = 16'h000b;
	localparam logic [15:0] VEC_EXT1 = 16'h0013;
	localparam logic [15:0] VEC_TMR1 = 16'h001b;
	localparam logic [15:0] VEC_UART = 16'h0023;
	localparam logic [15:0] VEC_TMR2 = 16'h002b;

	// ----------------------------------------
	// power control bits and reset values
	// ----------------------------------------
	localparam int IDLE_BIT_POS = 0;
	localparam int PD_BIT_POS = 1;
	localparam logic [7:0] POWER_CONTROL_REG_RST = 8'h00;
	localparam logic BOOT_CTRL_FACTORY = 1'b1;

	// interrupt source index in service order
	localparam int SRC_EXT0 = 0;
	localparam int SRC_WDOG = 1;
	localparam int SRC_TMR0 = 2;
	localparam int SRC_EXT1 = 3;
	localparam int SRC_TMR1 = 4;
	localparam int SRC_UART = 5;
	localparam int SRC_TMR2 = 6;

	typedef enum logic [2:0] {
		PM_RUN = 3'b001,
		PM_IDLE = 3'b010,
		PM_PDOWN = 3'b100
	} bspm_pmode_t;

	typedef struct packed {
		logic zero_boot_bit;
		logic user_vec_bit;
		logic [7:0] user_vec;
	} bspm_boot_cfg_t;

	typedef struct packed {
		logic valid;
		logic [2:0] src;
		logic [15:0] vector;
	} bspm_irq_sel_t;

endpackage

// file: bspm_boot_sel.sv
// boot start address selection
// assumes strap and config inputs are stable when sampled
`timescale 1ns/10ps
`default_nettype none
module bspm_boot_sel
	import bspm_pkg::*;
#(
	parameter bit LARGE_MEM = 1'b1
) (
	// selection inputs
	input wire logic i_ext_code_sel_n,
	input wire logic i_strap_low,
	input wire bspm_boot_cfg_t i_cfg,
	input wire logic [15:0] i_default_vec,
	// result
	output logic [15:0] o_boot_addr
);

	logic [15:0] user_addr;

	always_comb begin
		user_addr = 16'h0000;
		if (LARGE_MEM) begin
			user_addr[UVEC_LSB_LARGE +: 8] = i_cfg.user_vec;
		end else begin
			user_addr[UVEC_LSB_SMALL +: 8] = i_cfg.user_vec;
		end
	end

	always_comb begin
		if (!i_ext_code_sel_n) begin
			o_boot_addr = ADDR_ZERO;
		end else if (i_strap_low) begin
			o_boot_addr = i_cfg.user_vec_bit ? i_default_vec : user_addr;
		end else if (!i_cfg.zero_boot_bit) begin
			o_boot_addr = ADDR_ZERO;
		end else if (!i_cfg.user_vec_bit) begin
			o_boot_addr = user_addr;
		end else begin
			o_boot_addr = i_default_vec;
		end
	end

endmodule
`default_nettype wire

// file: bspm_irq_arb.sv
// fixed order interrupt arbiter over four priority levels
// assumes request and enable inputs already qualified by the caller
`timescale 1ns/10ps
`default_nettype none
module bspm_irq_arb
	import bspm_pkg::*;
(
	// requests
	input wire logic [NUM_IRQ-1:0] i_req,
	input wire logic [NUM_IRQ*PRIO_W-1:0] i_prio,
	// selection
	output bspm_irq_sel_t o_sel
);

	function automatic logic [15:0] vec_of(input logic [2:0] s);
		case (s)
			3'd0: vec_of = VEC_EXT0;
			3'd1: vec_of = VEC_WDOG;
			3'd2: vec_of = VEC_TMR0;
			3'd3: vec_of = VEC_EXT1;
			3'd4: vec_of = VEC_TMR1;
			3'd5: vec_of = VEC_UART;
			3'd6: vec_of = VEC_TMR2;
			default: vec_of = ADDR_ZERO;
		endcase
	endfunction

	// highest level first, then lowest index within a level
	always_comb begin
		o_sel = '0;
		for (int lvl = 3; lvl >= 0; lvl--) begin
			for (int s = NUM_IRQ-1; s >= 0; s--) begin
				if (!o_sel.valid && i_req[s] && (i_prio[s*PRIO_W +: PRIO_W] == lvl[PRIO_W-1:0])) begin
					o_sel.src = s[2:0];
				end
			end
			if (!o_sel.valid) begin
				for (int s = 0; s < NUM_IRQ; s++) begin
					if (i_req[s] && (i_prio[s*PRIO_W +: PRIO_W] == lvl[PRIO_W-1:0])) begin
						o_sel.valid = 1'b1;
					end
				end
			end
		end
		o_sel.vector = vec_of(o_sel.src);
	end

endmodule
`default_nettype wire

// file: bspm_assertions.sv
// concurrent checks on the ports of bspm_top
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module bspm_assertions
	import bspm_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// inputs watched
	input wire logic i_ce,
	input wire logic i_ext_irq0_pin_n,
	input wire logic i_ext_irq1_pin_n,
	input wire logic i_power_control_reg_wr,
	input wire logic [7:0] i_power_control_reg_wdata,
	input wire logic i_irq_ack,
	// outputs watched
	input wire logic [7:0] o_power_control_reg,
	input wire logic o_pc_halt,
	input wire logic o_clk_stop,
	input wire logic o_addr_latch_strobe,
	input wire logic o_program_fetch_strobe_n,
	input wire logic o_irq_req,
	input wire logic [2:0] o_irq_src,
	input wire logic [15:0] o_irq_vector
);
	localparam logic [15:0] VT [7] = '{VEC_EXT0, VEC_WDOG, VEC_TMR0, VEC_EXT1, VEC_TMR1, VEC_UART, VEC_TMR2};
	logic [15:0] low_cnt_ff;
	logic [15:0] nxt_low_cnt;

	// ----
	// wake pin low time in power-down
	// ----
	always_comb begin
		nxt_low_cnt = '0;
		if (o_clk_stop && !(i_ext_irq0_pin_n && i_ext_irq1_pin_n)) begin
			nxt_low_cnt = low_cnt_ff + 16'h0001;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			low_cnt_ff <= '0;
		end else if (i_ce) begin
			low_cnt_ff <= nxt_low_cnt;
		end
	end

	// ----
	// properties
	// ----
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_run_wr;
		i_ce && i_power_control_reg_wr && !o_pc_halt && !o_clk_stop && !o_irq_req;
	endsequence
	sequence s_wake;
		$fell(o_clk_stop) && !$past(i_sys_rst);
	endsequence

	chk_pd_entry: assert property (s_run_wr ##0 i_power_control_reg_wdata[1] |=> o_clk_stop && o_power_control_reg[1])
		else $error("power-down not entered");
	chk_idle_entry: assert property (s_run_wr ##0 i_power_control_reg_wdata[1:0] == 2'h1 |=> o_pc_halt && !o_clk_stop)
		else $error("idle not entered");
	chk_idle_strobes: assert property (o_pc_halt && !o_clk_stop |-> o_addr_latch_strobe && o_program_fetch_strobe_n)
		else $error("strobes not high in idle");
	chk_pd_strobes: assert property (o_clk_stop |-> !o_addr_latch_strobe && !o_program_fetch_strobe_n)
		else $error("strobes not low in power-down");
	chk_pd_stays: assert property (o_clk_stop && !$rose(i_ext_irq0_pin_n) && !$rose(i_ext_irq1_pin_n) |=> o_clk_stop)
		else $error("power-down left without pin release");
	chk_wake_hold: assert property (s_wake |-> $past(low_cnt_ff) >= 16'h0400)
		else $error("wake with short pin low time");
	chk_wake_source: assert property (s_wake |-> o_irq_req && (o_irq_src == 3'h0 || o_irq_src == 3'h3))
		else $error("power-down woken by wrong source");
	chk_service_clears: assert property ($rose(o_irq_req) |-> !o_pc_halt && !o_clk_stop && o_power_control_reg[1:0] == 2'h0)
		else $error("mode bits not cleared at service");
	chk_req_stands: assert property (o_irq_req && !i_irq_ack |=> o_irq_req && $stable(o_irq_vector))
		else $error("request dropped before ack");
	chk_vector_map: assert property (o_irq_req |-> o_irq_vector == VT[o_irq_src])
		else $error("vector does not match source");
endmodule

bind bspm_top bspm_assertions u_chk (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
	.i_ext_irq0_pin_n(i_ext_irq0_pin_n), .i_ext_irq1_pin_n(i_ext_irq1_pin_n),
	.i_power_control_reg_wr(i_power_control_reg_wr), .i_power_control_reg_wdata(i_power_control_reg_wdata),
	.i_irq_ack(i_irq_ack), .o_power_control_reg(o_power_control_reg), .o_pc_halt(o_pc_halt),
	.o_clk_stop(o_clk_stop), .o_addr_latch_strobe(o_addr_latch_strobe),
	.o_program_fetch_strobe_n(o_program_fetch_strobe_n), .o_irq_req(o_irq_req),
	.o_irq_src(o_irq_src), .o_irq_vector(o_irq_vector)
);
`default_nettype wire

// file: bspm_pin_model.sv
// pin side model: reset, code select, straps and wake pins
// assumes tasks are called from one process; port 1 pins pull up
`timescale 1ns/10ps
`default_nettype none
module bspm_pin_model (
	// clock
	input wire logic i_clk,
	// pins
	output logic o_rst,
	output logic o_sel_n,
	output logic [1:0] o_strap,
	output logic o_irq0_n,
	output logic o_irq1_n
);
	initial begin
		o_rst = 1'b1;
		o_sel_n = 1'b1;
		o_strap = 2'h3;
		o_irq0_n = 1'b1;
		o_irq1_n = 1'b1;
	end

	// reset pulse, straps held through release then pulled up
	task automatic pulse_reset(input logic sel_n, input logic [1:0] strap);
		@(posedge i_clk);
		o_rst <= 1'b1;
		o_sel_n <= sel_n;
		o_strap <= strap;
		repeat (2) @(posedge i_clk);
		o_rst <= 1'b0;
		@(posedge i_clk);
		o_strap <= 2'h3;
	endtask

	// wake pin held low for n cycles
	task automatic hold_wake(input int n);
		@(posedge i_clk);
		o_irq0_n <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_irq0_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: tb.sv
// self-checking bench for bspm_top
// assumes the pin model drives reset, straps and wake pins
`timescale 1ns/10ps
`default_nettype none
module tb
	import bspm_pkg::*;
;
	localparam logic [15:0] DVEC = 16'h1c00;
	localparam logic [15:0] VT [7] = '{VEC_EXT0, VEC_WDOG, VEC_TMR0, VEC_EXT1, VEC_TMR1, VEC_UART, VEC_TMR2};
	logic clk = 1'b0;
	logic rst, sel_n, irq0_n, irq1_n;
	logic [1:0] strap;
	logic [1:0] edge_md = 2'h0;
	logic cfg_wr = 1'b0, pc_wr = 1'b0, ack = 1'b0, gie = 1'b1;
	logic [7:0] pc_wd = 8'h00, fcfg, power_control_reg;
	bspm_boot_cfg_t cfg_wd = '0, boot_cfg;
	logic [6:0] flag = 7'h00, en = 7'h7f;
	logic [13:0] prio = 14'h0000;
	logic [15:0] boot_addr, vec;
	logic [2:0] src;
	logic valid, halt, cstop, ale, program_fetch_strobe_n_n, req;
	int fail_count = 0, samples_checked = 0;

	always #5 clk = ~clk;

	bspm_pin_model pins (.i_clk(clk), .o_rst(rst), .o_sel_n(sel_n), .o_strap(strap), .o_irq0_n(irq0_n),
		.o_irq1_n(irq1_n));
	bspm_top #(.DEFAULT_BOOT_VEC(DVEC)) uut (.i_clk(clk), .i_sys_rst(rst), .i_ce(1'b1),
		.i_external_code_select_n(sel_n), .i_port1_strap(strap), .i_ext_irq0_pin_n(irq0_n),
		.i_ext_irq1_pin_n(irq1_n), .i_boot_cfg_wr(cfg_wr), .i_boot_cfg_wdata(cfg_wd),
		.i_power_control_reg_wr(pc_wr), .i_power_control_reg_wdata(pc_wd), .i_irq_flag(flag),
		.i_irq_en(en), .i_irq_prio(prio), .i_global_irq_en(gie), .i_ext_irq_edge_mode(edge_md),
		.i_irq_ack(ack), .o_boot_addr(boot_addr), .o_boot_valid(valid), .o_flash_config_reg(fcfg),
		.o_boot_cfg(boot_cfg), .o_power_control_reg(power_control_reg), .o_pc_halt(halt), .o_clk_stop(cstop),
		.o_addr_latch_strobe(ale), .o_program_fetch_strobe_n(program_fetch_strobe_n_n), .o_irq_req(req),
		.o_irq_src(src), .o_irq_vector(vec));

	// ----
	// shared tasks
	// ----
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wait_req;
		for (int k = 0; k < 8 && req !== 1'b1; k++) @(negedge clk);
		chk("irq_req", {15'h0, req}, 16'h0001);
	endtask
	task automatic do_ack;
		@(posedge clk);
		ack <= 1'b1;
		flag <= 7'h00;
		@(posedge clk);
		ack <= 1'b0;
		@(negedge clk);
	endtask
	task automatic wr_power_control_reg(input logic [7:0] v);
		@(posedge clk);
		pc_wr <= 1'b1;
		pc_wd <= v;
		@(posedge clk);
		pc_wr <= 1'b0;
		@(negedge clk);
	endtask
	function automatic logic [15:0] boot_exp(input logic s, input logic [1:0] p, input bspm_boot_cfg_t c);
		if (!s)
			return 16'h0000;
		if (p != 2'h0 && !c.zero_boot_bit)
			return 16'h0000;
		return c.user_vec_bit ? DVEC : {2'h0, c.user_vec, 6'h00};
	endfunction

	// ----
	// scenarios
	// ----
	task automatic t_reset;
		@(negedge clk);
		chk("boot_cfg", {6'h00, boot_cfg}, 16'h0300);
		chk("boot_addr", boot_addr, DVEC);
		chk("run_state", {power_control_reg, 3'h0, halt, cstop, req, ale, program_fetch_strobe_n_n}, 16'h0003);
		$display("t_reset done");
	endtask
	task automatic t_boot;
		logic [12:0] tc [7] = '{13'h0300, 13'h1300, 13'h12a5, 13'h15a5, 13'h1aa5, 13'h1c3c, 13'h1f3c};
		bspm_boot_cfg_t c;
		foreach (tc[i]) begin
			c = tc[i][9:0];
			@(posedge clk);
			cfg_wr <= 1'b1;
			cfg_wd <= c;
			@(posedge clk);
			cfg_wr <= 1'b0;
			pins.pulse_reset(tc[i][12], tc[i][11:10]);
			@(negedge clk);
			chk("boot_addr", boot_addr, boot_exp(tc[i][12], tc[i][11:10], c));
			chk("strap_flag", {15'h0, fcfg[6]}, {15'h0, tc[i][11:10] == 2'h0});
			chk("boot_valid", {15'h0, valid}, 16'h0001);
		end
		$display("t_boot done");
	endtask
	task automatic t_idle;
		wr_power_control_reg(8'h01);
		chk("idle_state", {12'h0, halt, cstop, ale, program_fetch_strobe_n_n}, 16'h000b);
		@(posedge clk);
		flag[SRC_TMR0] <= 1'b1;
		wait_req;
		chk("irq_vector", vec, VEC_TMR0);
		chk("wake_state", {power_control_reg, 7'h0, halt}, 16'h0000);
		chk("boot_addr", boot_addr, DVEC);
		do_ack;
		$display("t_idle done");
	endtask
	task automatic t_prio;
		for (int s = 0; s < NUM_IRQ; s++) begin
			@(posedge clk);
			flag <= 7'h7f << s;
			wait_req;
			chk("irq_src", {13'h0, src}, 16'(s));
			chk("irq_vector", vec, VT[s]);
			do_ack;
		end
		@(posedge clk);
		prio <= 14'h3000;
		flag <= 7'h7f;
		wait_req;
		chk("irq_src", {13'h0, src}, 16'h0006);
		do_ack;
		@(posedge clk);
		prio <= 14'h0000;
		en <= 7'h7e;
		flag <= 7'h7f;
		wait_req;
		chk("irq_src", {13'h0, src}, 16'h0001);
		do_ack;
		@(posedge clk);
		en <= 7'h7f;
		$display("t_prio done");
	endtask
	task automatic t_pdown;
		wr_power_control_reg(8'h03);
		chk("pd_state", {13'h0, cstop, ale, program_fetch_strobe_n_n}, 16'h0004);
		@(posedge clk);
		flag <= 7'h04;
		repeat (4) @(negedge clk);
		chk("irq_req", {15'h0, req}, 16'h0000);
		@(posedge clk);
		flag <= 7'h00;
		edge_md <= 2'h1;
		pins.hold_wake(8);
		repeat (4) @(negedge clk);
		chk("edge_wake", {14'h0, req, cstop}, 16'h0001);
		@(posedge clk);
		edge_md <= 2'h0;
		pins.hold_wake(1030);
		wait_req;
		chk("irq_vector", vec, VEC_EXT0);
		chk("wake_state", {power_control_reg, 5'h0, cstop, ale, program_fetch_strobe_n_n}, 16'h0003);
		chk("boot_addr", boot_addr, DVEC);
		do_ack;
		$display("t_pdown done");
	endtask
	task automatic t_pd_reset;
		wr_power_control_reg(8'h02);
		pins.pulse_reset(1'b1, 2'h0);
		@(negedge clk);
		chk("reset_state", {power_control_reg, 7'h0, cstop}, 16'h0000);
		chk("strap_flag", {15'h0, fcfg[6]}, 16'h0001);
		$display("t_pd_reset done");
	endtask

	initial begin
		pins.pulse_reset(1'b1, 2'h3);
		t_reset;
		t_boot;
		t_idle;
		t_prio;
		t_pdown;
		t_pd_reset;
		end_of_test;
	end
	initial begin
		#100000;
		fail_count++;
		end_of_test;
	end
endmodule
`default_nettype wire
